// ---- hdl/srf_pkg.sv ----
// shared constants and types for the status flag readback registers
`default_nettype none
package srf_pkg;
    // register map
    localparam logic [7:0] SRF_ADDR_FAULT = 8'h02;
    localparam logic [7:0] SRF_ADDR_RAIL = 8'h03;
    // field positions in the rail health register
    localparam int SRF_UV_LSB = 3;
    localparam int SRF_PG_LSB = 0;
    // reset values
    localparam logic [7:0] SRF_FAULT_RST = 8'h00;
    localparam logic [2:0] SRF_UV_RST = 3'h0;
    localparam logic [2:0] SRF_PG_RST = 3'h0;
    // serial slave address, value is arbitrary
    localparam logic [6:0] SRF_DEV_ADDR_DEF = 7'h2A;

    // fault sources, D7 down to D0
    typedef struct packed {
        logic brownout_flag;
        logic thermal_shutdown_flag;
        logic thermal_early_warning;
        logic main_input_lockout;
        logic second_input_lockout;
        logic third_input_lockout;
        logic usb_switch_fault_ch1;
        logic usb_switch_fault_ch2;
    } srf_fault_t;

    typedef struct packed {
        logic rail1_undervoltage;
        logic rail2_undervoltage;
        logic rail3_undervoltage;
    } srf_uv_t;

    typedef struct packed {
        logic rail1_power_good;
        logic rail2_power_good;
        logic rail3_power_good;
    } srf_pg_t;

    typedef enum logic [2:0] {
        SRF_IDLE = 3'b000,
        SRF_ADDR = 3'b001,
        SRF_ADDR_ACK = 3'b010,
        SRF_WR_REG = 3'b011,
        SRF_WR_ACK = 3'b100,
        SRF_RD_BYTE = 3'b101,
        SRF_RD_ACK = 3'b110,
        SRF_RD_NEXT = 3'b111
    } srf_state_t;
endpackage
`default_nettype wire

// ---- hdl/srf_sticky_flags.sv ----
// bank of sticky event flags, clear on read, set wins over clear
`default_nettype none
module srf_sticky_flags #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // events and read clear
    input wire logic [W-1:0] set_bits,
    input wire logic clr_read,
    // latched flags
    output logic [W-1:0] flags_q
);
    if (W < 1) begin : g_bad_width
        $error("srf_sticky_flags needs at least one flag");
    end

    // an event in the clearing cycle survives the read
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags_q <= RST;
        end else if (clr_read) begin
            flags_q <= set_bits;
        end else begin
            flags_q <= flags_q | set_bits;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/srf_status_regs.sv ----
// status flag readback registers behind the serial control bus
`default_nettype none
// Functional notes
// - reading fault register clears all its flags
// - reading rail register clears only undervoltage bits
// - release attention after both reads or flags clear
// - rail undervoltage flags in bits five to three
// - rail register at 0x03, power good low bits
// - fault register bit order brownout down to usb
module srf_status_regs import srf_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = SRF_DEV_ADDR_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // raw conditions from the analog supervisors
    input wire srf_fault_t fault_in,
    input wire srf_uv_t uv_in,
    input wire srf_pg_t pg_in,
    // serial control bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // open drain attention pin
    output logic att_out,
    output logic att_oe_n
);
    if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF) begin : g_bad_addr
        $error("srf_status_regs slave address is in a reserved range");
    end

    srf_state_t state_q;
    logic scl_prev_q, sda_prev_q;
    logic [2:0] cnt_q;
    logic done_q, rw_q;
    logic [7:0] shift_q, tx_q, ptr_q;
    logic [7:0] fault_q;
    logic [2:0] uv_q;
    srf_pg_t pg_q;
    logic seen_fault_q, seen_rail_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    logic load_now, rd_fault_p, rd_rail_p, new_evt, pending;
    logic [7:0] rd_byte;

    // register contents as the host sees them
    function automatic logic [7:0] reg_read(
        input logic [7:0] addr,
        input logic [7:0] fault,
        input logic [2:0] uv,
        input logic [2:0] pg
    );
        logic [7:0] r;
        r = 8'h00;
        if (addr == SRF_ADDR_FAULT) begin
            r = fault;
        end else if (addr == SRF_ADDR_RAIL) begin
            r[SRF_UV_LSB +: 3] = uv;
            r[SRF_PG_LSB +: 3] = pg;
        end
        return r;
    endfunction

    // pins are synchronous, one stage of history finds edges
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
        end
    end

    assign scl_rise = scl_in & ~scl_prev_q;
    assign scl_fall = ~scl_in & scl_prev_q;
    assign start_c = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
    assign stop_c = scl_in & scl_prev_q & ~sda_prev_q & sda_in;

    // a byte is fetched on the falling edge that starts its first bit
    assign load_now = scl_fall & ~start_c & ~stop_c &
        ((state_q == SRF_ADDR_ACK && rw_q) || state_q == SRF_RD_NEXT);
    assign rd_byte = reg_read(ptr_q, fault_q, uv_q, pg_q);
    assign rd_fault_p = load_now && ptr_q == SRF_ADDR_FAULT;
    assign rd_rail_p = load_now && ptr_q == SRF_ADDR_RAIL;

    // serial slave: address, pointer write, byte reads
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= SRF_IDLE;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            rw_q <= 1'b0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            sda_oe_n <= 1'b1;
        end else if (stop_c) begin
            state_q <= SRF_IDLE;
            sda_oe_n <= 1'b1;
        end else if (start_c) begin
            state_q <= SRF_ADDR;
            cnt_q <= 3'h0;
            done_q <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (scl_rise) begin
            case (state_q)
                SRF_ADDR, SRF_WR_REG: begin
                    shift_q <= {shift_q[6:0], sda_in};
                    cnt_q <= cnt_q + 3'h1;
                    done_q <= (cnt_q == 3'h7);
                end
                SRF_RD_BYTE: begin
                    cnt_q <= cnt_q + 3'h1;
                    done_q <= (cnt_q == 3'h7);
                end
                // a not-acknowledge ends the read burst
                SRF_RD_ACK: begin
                    state_q <= sda_in ? SRF_IDLE : SRF_RD_NEXT;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_q)
                SRF_ADDR: begin
                    if (done_q) begin
                        done_q <= 1'b0;
                        if (shift_q[7:1] == DEV_ADDR) begin
                            sda_oe_n <= 1'b0;
                            rw_q <= shift_q[0];
                            state_q <= SRF_ADDR_ACK;
                        end else begin
                            state_q <= SRF_IDLE;
                        end
                    end
                end
                SRF_ADDR_ACK, SRF_RD_NEXT: begin
                    cnt_q <= 3'h0;
                    if (load_now) begin
                        tx_q <= {rd_byte[6:0], 1'b0};
                        sda_oe_n <= rd_byte[7];
                        state_q <= SRF_RD_BYTE;
                    end else begin
                        sda_oe_n <= 1'b1;
                        state_q <= SRF_WR_REG;
                    end
                end
                SRF_WR_REG: begin
                    if (done_q) begin
                        done_q <= 1'b0;
                        sda_oe_n <= 1'b0;
                        state_q <= SRF_WR_ACK;
                    end
                end
                SRF_WR_ACK: begin
                    sda_oe_n <= 1'b1;
                    cnt_q <= 3'h0;
                    state_q <= SRF_WR_REG;
                end
                SRF_RD_BYTE: begin
                    if (done_q) begin
                        done_q <= 1'b0;
                        sda_oe_n <= 1'b1;
                        state_q <= SRF_RD_ACK;
                    end else begin
                        sda_oe_n <= tx_q[7];
                        tx_q <= {tx_q[6:0], 1'b0};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // register pointer: last written byte, then auto increment
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ptr_q <= 8'h00;
        end else if (scl_fall && !start_c && !stop_c && state_q == SRF_WR_REG
                     && done_q) begin
            ptr_q <= shift_q;
        end else if (scl_rise && !start_c && !stop_c &&
                     state_q == SRF_RD_ACK && !sda_in) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    srf_sticky_flags #(.W(8), .RST(SRF_FAULT_RST)) u_fault_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .set_bits(fault_in),
        .clr_read(rd_fault_p),
        .flags_q(fault_q)
    );

    // power good is live and never latched, so it is outside the bank
    srf_sticky_flags #(.W(3), .RST(SRF_UV_RST)) u_uv_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .set_bits(uv_in),
        .clr_read(rd_rail_p),
        .flags_q(uv_q)
    );

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pg_q <= SRF_PG_RST;
        end else begin
            pg_q <= pg_in;
        end
    end

    // read marks; a fresh event restarts the fault and rail read pair, read in either order
    assign new_evt = |(fault_in & ~fault_q) | |(uv_in & ~uv_q);
    assign pending = |fault_q | |uv_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seen_fault_q <= 1'b0;
            seen_rail_q <= 1'b0;
        end else if (new_evt) begin
            seen_fault_q <= 1'b0;
            seen_rail_q <= 1'b0;
        end else begin
            if (rd_fault_p) begin
                seen_fault_q <= 1'b1;
            end
            if (rd_rail_p) begin
                seen_rail_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            att_oe_n <= 1'b1;
        end else begin
            att_oe_n <= ~(pending & ~(seen_fault_q & seen_rail_q));
        end
    end

    // open drain pins only ever pull low
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
            att_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            att_out <= 1'b0;
        end
    end

    fault_clear_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_fault_p && fault_in == '0 |=> fault_q == 8'h00)
        else $error("fault flags not cleared by read");

    uv_clear_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_rail_p && uv_in == '0 |=> uv_q == 3'h0 && pg_q == $past(pg_in))
        else $error("rail read cleared wrong bits");

    evt_survives_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        fault_in != '0 |=> (fault_q & $past(fault_in)) == $past(fault_in))
        else $error("fault event lost");

    att_release_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !pending ##1 !pending |-> att_oe_n)
        else $error("attention held with no flags");

    att_both_read_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        seen_fault_q && seen_rail_q |=> att_oe_n)
        else $error("attention held after both reads");

    att_drive_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(pending) |=> !att_oe_n [*1])
        else $error("attention not driven on new flag");

    rail_layout_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_rail_p |-> rd_byte == {2'b00, uv_q, pg_q})
        else $error("rail register layout wrong");

    fault_layout_a: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        rd_fault_p |-> rd_byte == fault_q && sda_oe_n == $past(sda_oe_n) ##1
        sda_oe_n == $past(rd_byte[7]))
        else $error("fault register byte wrong on the bus");
endmodule
`default_nettype wire

// ---- testbench/srf_host_model.sv ----
// serial bus host model that reads the status registers
`default_nettype none
module srf_host_model import srf_pkg::*; (
    // clock
    input wire logic sys_clk,
    // bus pins
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // four cycles a level, slave needs three
    task automatic hold;
        repeat (4) @(negedge sys_clk);
    endtask
    task automatic start;
        sda_drv = 1'b1;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b0;
        hold();
        scl = 1'b0;
    endtask
    // extra cycle after scl falls so sda never moves with it
    task automatic bit_out(input logic b);
        sda_drv = b;
        hold();
        scl = 1'b1;
        hold();
        scl = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic bit_in(output logic b);
        sda_drv = 1'b1;
        hold();
        scl = 1'b1;
        repeat (2) @(negedge sys_clk);
        b = sda_line;
        repeat (2) @(negedge sys_clk);
        scl = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic wbyte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
        bit_in(b);
        ack = ~b;
    endtask
    // pointer write, repeated start, then n bytes, last one nacked
    task automatic read(input logic [7:0] ptr, input int n,
                        output logic [15:0] d, output logic ok);
        logic a;
        logic [7:0] v;
        d = 16'h0000;
        start();
        wbyte({SRF_DEV_ADDR_DEF, 1'b0}, a);
        ok = a;
        wbyte(ptr, a);
        ok &= a;
        start();
        wbyte({SRF_DEV_ADDR_DEF, 1'b1}, a);
        ok &= a;
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_in(v[i]);
            end
            bit_out(k == n - 1);
            d = {d[7:0], v};
        end
        sda_drv = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_drv = 1'b1;
        hold();
    endtask
endmodule
`default_nettype wire

// ---- testbench/srf_status_regs_tb.sv ----
// self-checking bench for the status flag readback registers
`default_nettype none
module srf_status_regs_tb import srf_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk;
    logic sys_rst;
    srf_fault_t fault_in;
    srf_uv_t uv_in;
    srf_pg_t pg_in;
    logic scl, sda_drv, sda_line, sda_out, sda_oe_n, att_out, att_oe_n;
    logic [15:0] d;
    logic ok;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    // open drain with pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    srf_status_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .fault_in(fault_in), .uv_in(uv_in), .pg_in(pg_in),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .att_out(att_out), .att_oe_n(att_oe_n));
    srf_host_model host (.sys_clk(sys_clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // whole run needs about 3500 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] ptr, input int n);
        host.read(ptr, n, d, ok);
        chk("ack", 8'h01, {7'h00, ok});
    endtask
    // pin level with its pull-up, so att_out is watched as well
    task automatic att(input logic e);
        chk("att_oe_n", {7'h00, e}, {7'h00, att_oe_n});
        chk("att pin", {7'h00, e}, {7'h00, att_oe_n | att_out});
    endtask
    task automatic t_reset;
        att(1'b1);
        rd(SRF_ADDR_FAULT, 2);
        chk("reset regs", 8'h00, d[15:8] | d[7:0]);
        $display("test reset done");
    endtask
    // pattern is not a bit palindrome, so a reversed order shows
    task automatic t_fault;
        fault_in = 8'hC1;
        repeat (2) @(negedge sys_clk);
        fault_in = 8'h00;
        repeat (3) @(negedge sys_clk);
        att(1'b0);
        rd(SRF_ADDR_FAULT, 1);
        chk("fault", 8'hC1, d[7:0]);
        att(1'b1);
        rd(SRF_ADDR_FAULT, 1);
        chk("fault clr", 8'h00, d[7:0]);
        $display("test fault done");
    endtask
    task automatic t_rail;
        pg_in = 3'b011;
        uv_in = 3'b110;
        repeat (2) @(negedge sys_clk);
        uv_in = 3'b000;
        repeat (3) @(negedge sys_clk);
        att(1'b0);
        rd(SRF_ADDR_RAIL, 1);
        chk("rail", 8'h33, d[7:0]);
        rd(SRF_ADDR_RAIL, 1);
        chk("rail clr", 8'h03, d[7:0]);
        att(1'b1);
        $display("test rail done");
    endtask
    // conditions held on: only the double read releases attention
    task automatic t_burst;
        fault_in = 8'h01;
        uv_in = 3'b010;
        repeat (4) @(negedge sys_clk);
        att(1'b0);
        rd(SRF_ADDR_FAULT, 1);
        chk("fault only", 8'h01, d[7:0]);
        att(1'b0);
        rd(SRF_ADDR_FAULT, 2);
        chk("burst", 8'h01, d[15:8]);
        chk("burst rail", 8'h13, d[7:0]);
        att(1'b1);
        fault_in = 8'h00;
        uv_in = 3'b000;
        rd(8'h05, 1);
        chk("unmapped", 8'h00, d[7:0]);
        $display("test burst done");
    endtask
    // reset in mid-run drops latched flags and pulled attention
    task automatic t_rerun;
        fault_in = 8'h02;
        repeat (3) @(negedge sys_clk);
        fault_in = 8'h00;
        att(1'b0);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        att(1'b1);
        rd(SRF_ADDR_FAULT, 2);
        chk("rerun fault", 8'h00, d[15:8]);
        chk("rerun rail", 8'h03, d[7:0]);
        $display("test rerun done");
    endtask
    initial begin
        sys_rst = 1'b1;
        fault_in = 8'h00;
        uv_in = 3'b000;
        pg_in = 3'b000;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        t_reset();
        t_fault();
        t_rail();
        t_burst();
        t_rerun();
        stop_test();
    end
endmodule
`default_nettype wire
